// >>> include/riomap_pkg.sv
package riomap_pkg;
  // unit type codes
  typedef enum logic [1:0] {
    RIOM_UNIT_NONE,
    RIOM_UNIT_DIO32,
    RIOM_UNIT_DIO64,
    RIOM_UNIT_DIO64_AO
  } riom_unit_e;
  localparam logic [1:0]  RIOM_UNIT_DIO32_AI = 2'h3;
  localparam int          RIOM_NUM_UNITS     = 8;
  localparam int          RIOM_MAX_POINTS    = 8;
  localparam logic [11:0] RIOM_BLOCK_SIZE    = 12'h020;
  localparam logic [11:0] RIOM_P1_IN_BASE    = 12'h100;
  localparam logic [11:0] RIOM_P1_OUT_BASE   = 12'h100;
  localparam logic [11:0] RIOM_P2_IN_BASE    = 12'h640;
  localparam logic [11:0] RIOM_P2_OUT_BASE   = 12'h740;
  localparam logic [11:0] RIOM_P1_IN_FREG    = 12'h080;
  localparam logic [11:0] RIOM_P1_OUT_FREG   = 12'h180;
  localparam logic [11:0] RIOM_AO_FREG_BASE  = 12'h100;
  localparam int          RIOM_AO_FREG_NUM   = 4;
  localparam logic [2:0]  RIOM_P1_MAX_SW     = 3'h3;
  localparam logic [2:0]  RIOM_P1_FREG_SW    = 3'h2;
  localparam logic [11:0] RIOM_PANEL_RST_X   = 12'h108;
  localparam logic [11:0] RIOM_RIGHT_OUT_PTS = 12'h010;
endpackage : riomap_pkg

// >>> src/riomap_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// - channel switch n maps inputs to X block n*0x20, outputs to matching Y block.
// - right-side card maps only the lower 16 outputs of the selected Y block.
// - analog outputs take file registers 0x100..0x103 in ascending switch order.
// - single-card unit occupies one point, two-card and base unit two.
// - each unit type reports its input and output point counts; analog input points always read 0.
// - type suffix 0 means sink outputs, 1 means source outputs.
// - a configuration input picks one of two operation-board patterns.
// - pattern 1 puts board I/O from X100/Y100, switches 0 and 1 take blocks.
// - pattern 1 switch 2 and 3 map to file register pairs 0x80/0x180 upward.
// - pattern 2 puts board I/O from X640/Y740, 0x20 points per switch.
// - pattern 2 switch 7 ends at X73F and Y83F, contiguous ranges.
// - board input X108 is reserved as the board reset signal.
// - no analog output is offered through the operation-board remote I/O.
module riomap_top #(
  parameter int NUM_UNITS = riomap_pkg::RIOM_NUM_UNITS
) (
  input  wire logic        clk,           // 10 MHz clock
  input  wire logic        rst_b,         // synchronous reset, active low
  input  wire logic        clk_en,        // freezes all state while low, unless rst_b is low
  input  wire logic [2:0]  unit_sel,      // channel-1 unit slot to look up
  input  wire logic [1:0]  unit_type,     // type of that unit
  input  wire logic        unit_suffix,   // output type suffix of that unit
  input  wire logic [2:0]  unit_sw,       // channel switch of that unit
  input  wire logic        unit_right,    // address the right-side card
  input  wire logic        unit_base,     // slot holds the base I/O unit
  input  wire logic        board_valid,   // board unit lookup present
  input  wire logic [2:0]  board_sw,      // board unit channel switch
  input  wire logic        board_has_ao,  // board unit has analog capability
  input  wire logic        pattern_sel,   // 0 pattern 1, 1 pattern 2
  output logic [11:0] x_start,            // first input device of the unit
  output logic [11:0] y_start,            // first output device of the unit
  output logic [11:0] y_end,              // last output device of the unit
  output logic [6:0]  in_pts,             // input points of the unit
  output logic [5:0]  out_pts,            // output points of the unit
  output logic [2:0]  ai_pts,             // analog input points
  output logic        ao_present,         // unit has an analog output
  output logic [11:0] ao_freg,            // file register of the analog output
  output logic        out_source,         // outputs are source type
  output logic [3:0]  occ_total,          // summed occupied points
  output logic [11:0] bx_start,           // board first input device or register
  output logic [11:0] by_start,           // board first output device or register
  output logic        b_freg,             // board maps to file registers
  output logic        b_ao_en,            // board analog output enable
  output logic [11:0] b_reset_x,          // reserved board reset input device
  output logic        cfg_err             // configuration error flag
);
  // refuse slot counts that the 3-bit slot index and the 8-slot tables cannot hold
  if (NUM_UNITS < 1 || NUM_UNITS > 8) begin : g_bad_units
    $error("NUM_UNITS must be 1..8");
  end

  typedef struct packed {
    logic [7:0]  present;
    logic [15:0] occ;
    logic [7:0]  has_ao;
    logic [11:0] x_start;
    logic [11:0] y_start;
    logic [11:0] y_end;
    logic [6:0]  in_pts;
    logic [5:0]  out_pts;
    logic [2:0]  ai_pts;
    logic        ao_present;
    logic [11:0] ao_freg;
    logic        out_source;
    logic [3:0]  occ_total;
    logic [11:0] bx_start;
    logic [11:0] by_start;
    logic        b_freg;
    logic        b_ao_en;
    logic [11:0] b_reset_x;
    logic        cfg_err;
  } riom_state_s;

  riom_state_s s_q;
  riom_state_s s_d;

  // occupied points for one unit type
  function automatic logic [1:0] riom_occ(input logic [1:0] t, input logic base);
    logic [1:0] pts;
    if (base) begin
      pts = 2'h2;
    end else begin
      case (t)
        2'h0:    pts = 2'h0;
        2'h1:    pts = 2'h1;
        default: pts = 2'h2;
      endcase
    end
    riom_occ = pts;
  endfunction : riom_occ

  // first device of the 32-point block picked by a channel switch
  function automatic logic [11:0] riom_block(input logic [2:0] sw);
    riom_block = 12'(sw) * riomap_pkg::RIOM_BLOCK_SIZE;
  endfunction : riom_block

  // offset of a file register pair; each switch value takes two registers
  function automatic logic [11:0] riom_pair(input logic sw_lsb);
    riom_pair = {10'h000, sw_lsb, 1'b0};
  endfunction : riom_pair

  // next state computation
  always_comb begin
    logic [4:0]  sum;
    logic [2:0]  rank;
    logic [11:0] blk;
    logic [11:0] bblk;
    logic        is_ao;
    s_d  = s_q;
    // five bits: eight two-point slots sum to 16, which would wrap a 4-bit total
    sum  = 5'h00;
    rank = 3'h0;
    blk  = riom_block(unit_sw);
    bblk = riom_block(board_sw);
    is_ao = unit_base || unit_type == 2'(riomap_pkg::RIOM_UNIT_DIO64_AO)
            || unit_type == riomap_pkg::RIOM_UNIT_DIO32_AI;
    // record the unit in its slot
    if (32'(unit_sel) < NUM_UNITS) begin
      s_d.present[unit_sel]   = unit_type != 2'h0 || unit_base;
      s_d.occ[2*unit_sel +: 2] = riom_occ(unit_type, unit_base);
      s_d.has_ao[unit_sel]    = is_ao;
    end
    for (int i = 0; i < 8; i++) begin
      sum = sum + {3'h0, s_d.occ[2*i +: 2]};
    end
    // analog register rank: count lower switch numbers carrying analog output
    // only slots that hold a unit take part, so a cleared slot frees its register
    for (int i = 0; i < 8; i++) begin
      if (s_d.present[i] && s_d.has_ao[i] && 3'(i) < unit_sw) rank = rank + 3'h1;
    end
    s_d.x_start    = blk;
    s_d.y_start    = blk;
    s_d.y_end      = unit_right ? blk + riomap_pkg::RIOM_RIGHT_OUT_PTS - 12'h001
                                : blk + riomap_pkg::RIOM_BLOCK_SIZE - 12'h001;
    // point counts of the unit type just looked up
    case (unit_type)
      2'h1: begin
        s_d.in_pts  = 7'h20;
        s_d.out_pts = 6'h20;
        s_d.ai_pts  = 3'h0;
      end
      2'h2: begin
        s_d.in_pts  = 7'h40;
        s_d.out_pts = 6'h30;
        s_d.ai_pts  = 3'h0;
      end
      2'h3: begin
        s_d.in_pts  = 7'h40;
        s_d.out_pts = 6'h30;
        s_d.ai_pts  = 3'h0;
      end
      default: begin
        s_d.in_pts  = 7'h00;
        s_d.out_pts = 6'h00;
        s_d.ai_pts  = 3'h0;
      end
    endcase
    // only the first four analog outputs get a register, the rest are not mapped
    s_d.ao_present = is_ao && 32'(rank) < riomap_pkg::RIOM_AO_FREG_NUM;
    s_d.ao_freg    = riomap_pkg::RIOM_AO_FREG_BASE + {9'h000, rank};
    s_d.out_source = unit_suffix;
    // the total port is four bits wide, so a full channel of 16 shows as 15
    s_d.occ_total  = sum > 5'h0F ? 4'hF : sum[3:0];
    // operation board mapping
    if (!pattern_sel) begin
      if (board_sw >= riomap_pkg::RIOM_P1_FREG_SW) begin
        s_d.b_freg   = 1'b1;
        s_d.bx_start = riomap_pkg::RIOM_P1_IN_FREG + riom_pair(board_sw[0]);
        s_d.by_start = riomap_pkg::RIOM_P1_OUT_FREG + riom_pair(board_sw[0]);
      end else begin
        s_d.b_freg   = 1'b0;
        s_d.bx_start = riomap_pkg::RIOM_P1_IN_BASE + bblk;
        s_d.by_start = riomap_pkg::RIOM_P1_OUT_BASE + bblk;
      end
    end else begin
      s_d.b_freg   = 1'b0;
      s_d.bx_start = riomap_pkg::RIOM_P2_IN_BASE + bblk;
      s_d.by_start = riomap_pkg::RIOM_P2_OUT_BASE + bblk;
    end
    // board analog output stays off even when the attached unit could drive one
    s_d.b_ao_en   = 1'b0 & board_has_ao;
    // the board reset input is fixed and never handed to another use
    s_d.b_reset_x = riomap_pkg::RIOM_PANEL_RST_X;
    // error on an overloaded channel or a board switch beyond pattern 1's range
    s_d.cfg_err   = sum > 5'(riomap_pkg::RIOM_MAX_POINTS)
                    || (board_valid && !pattern_sel && board_sw > riomap_pkg::RIOM_P1_MAX_SW);
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  // unit lookup results
  assign x_start    = s_q.x_start;
  assign y_start    = s_q.y_start;
  assign y_end      = s_q.y_end;
  assign in_pts     = s_q.in_pts;
  assign out_pts    = s_q.out_pts;
  assign ai_pts     = s_q.ai_pts;
  assign ao_present = s_q.ao_present;
  assign ao_freg    = s_q.ao_freg;
  assign out_source = s_q.out_source;
  assign occ_total  = s_q.occ_total;
  // operation board results
  assign bx_start   = s_q.bx_start;
  assign by_start   = s_q.by_start;
  assign b_freg     = s_q.b_freg;
  assign b_ao_en    = s_q.b_ao_en;
  assign b_reset_x  = s_q.b_reset_x;
  assign cfg_err    = s_q.cfg_err;
endmodule : riomap_top

// >>> sim/riomap_assertions.sv
`timescale 1ns/1ns
module riomap_assertions #(parameter int NUM_UNITS = 8) (
  input wire logic        clk, rst_b, clk_en, unit_right, unit_suffix, board_valid, pattern_sel, // stimulus
  input wire logic [1:0]  unit_type,                                       // unit type code
  input wire logic [2:0]  unit_sel, unit_sw, board_sw,                     // slot and switches
  input wire logic [11:0] x_start, y_start, y_end, bx_start, by_start, b_reset_x, // addresses
  input wire logic [6:0]  in_pts,                                          // input points
  input wire logic [5:0]  out_pts,                                         // output points
  input wire logic        out_source, b_freg, b_ao_en                      // flags
);
  logic tk_q;  // last edge took a request
  logic uv_q;  // last edge stored a real unit
  // remember what the previous edge accepted
  always_ff @(posedge clk) begin
    tk_q <= rst_b & clk_en;
    uv_q <= rst_b & clk_en & (unit_sel < NUM_UNITS) & (unit_type != 2'h0);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_x_block: assert property (uv_q |-> x_start == {4'h0, $past(unit_sw), 5'h00} && y_start == x_start)
    else $error("unit block");
  a_y_end: assert property (uv_q |-> y_end == y_start + ($past(unit_right) ? 12'h00F : 12'h01F))
    else $error("unit end");
  a_pts_type: assert property (uv_q |-> in_pts == ($past(unit_type) == 2'h1 ? 7'h20 : 7'h40)
    && out_pts == ($past(unit_type) == 2'h1 ? 6'h20 : 6'h30)) else $error("points");
  a_out_kind: assert property (uv_q |-> out_source == $past(unit_suffix)) else $error("suffix");
  a_reset_x: assert property (tk_q |-> b_reset_x == 12'h108) else $error("board reset");
  a_no_ao: assert property (tk_q |-> !b_ao_en) else $error("board analog");
  a_p2_board: assert property (tk_q && $past(board_valid && pattern_sel) |-> !b_freg
    && bx_start == 12'h640 + {4'h0, $past(board_sw), 5'h00}) else $error("pattern 2");
  a_p1_block: assert property (tk_q && $past(board_valid && !pattern_sel && board_sw < 3'h2) |-> !b_freg
    && by_start == 12'h100 + {4'h0, $past(board_sw), 5'h00}) else $error("pattern 1");
  a_p1_freg: assert property (tk_q && $past(board_valid && !pattern_sel && board_sw[2:1] == 2'h1)
    |-> b_freg && bx_start == {10'h020, $past(board_sw[0]), 1'b0}) else $error("registers");
  c_right: cover property (uv_q && $past(unit_right));
  c_freg: cover property (b_freg);
  c_p2: cover property (tk_q && $past(pattern_sel));
endmodule : riomap_assertions
bind riomap_top riomap_assertions #(.NUM_UNITS(NUM_UNITS)) u_riomap_assertions (.*);

// >>> sim/riomap_units.sv
`timescale 1ns/1ns
module riomap_units (
  input  wire logic [2:0] idx,     // slot asked for
  input  wire logic       over,    // add units beyond the limit
  output logic [1:0]      typ,     // unit type code
  output logic            spec_sw  // unused switch position
);
  // unused digital_io_spec_switch stays off
  assign spec_sw = 1'b0;
  // five units filling eight points, more only when overloaded
  assign typ = idx == 3'h0 || idx == 3'h4 ? 2'h2 : idx == 3'h2 ? 2'h3 : idx < 3'h4 ? 2'h1 :
               over ? (idx[0] ? 2'h2 : 2'h3) : 2'h0;
endmodule : riomap_units

// >>> sim/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clk = 0, rst_b = 0, right = 0, bval = 0, psel = 0, over = 0, en = 1, base = 0, spec_sw;
  logic [2:0] sel = 0, bsw = 0;
  logic [1:0] typ;
  logic [11:0] xs, ys, ye, aof, bx, by, rx;
  logic [6:0] ipt;
  logic [5:0] opt;
  logic [3:0] occ;
  logic src, aop, bfr, baoe, cerr;
  int err_total = 0, comparisons = 0;
  riomap_units u_riomap_units (.idx(sel), .over(over), .typ(typ), .spec_sw(spec_sw));
  riomap_top #(.NUM_UNITS(7)) u_riomap_top (.clk(clk), .rst_b(rst_b), .clk_en(en), .unit_sel(sel),
    .unit_type(typ), .unit_suffix(sel[0]), .unit_sw(sel), .unit_right(right), .unit_base(base),
    .board_valid(bval), .board_sw(bsw), .board_has_ao(1'b1), .pattern_sel(psel), .x_start(xs),
    .y_start(ys), .y_end(ye), .in_pts(ipt), .out_pts(opt), .ai_pts(), .ao_present(aop), .ao_freg(aof),
    .out_source(src), .occ_total(occ), .bx_start(bx), .by_start(by), .b_freg(bfr), .b_ao_en(baoe),
    .b_reset_x(rx), .cfg_err(cerr));
  // clock of 100 ns period
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  // every board switch in both patterns
  task automatic t_board;
    bval = 1;
    for (int s = 0; s < 16; s++) begin
      psel = s[3];
      bsw = s[2:0];
      step;
      chk(cerr, 12'(s < 8 && s > 3));
      chk(baoe, 0);
      chk(rx, 12'h108);
      if (s > 7) chk(by, 12'(12'h640 + s * 32));
      if (s < 2) chk(bx, 12'(12'h100 + s * 32));
      if (s[3:1] == 1) chk(by, 12'(12'h17C + s * 2));
    end
  endtask : t_board
  // fill the channel slot by slot
  task automatic t_load;
    logic [3:0] n;
    n = 0;
    for (int i = 0; i < 5; i++) begin
      sel = i[2:0];
      right = i == 2;
      #1 n += typ == 2'h1 ? 4'h1 : 4'h2;
      step;
      chk(xs, 12'(i * 32));
      chk(ye, 12'(i * 32 + (i == 2 ? 15 : 31)));
      chk(ipt, typ == 2'h1 ? 12'h020 : 12'h040);
      chk(opt, typ == 2'h1 ? 12'h020 : 12'h030);
      chk(src, 12'(i % 2));
      chk(occ, n);
    end
  endtask : t_load
  // overload the channel, then hit a refused slot
  task automatic t_over;
    over = 1;
    sel = 3'h6;
    right = 0;
    step;
    chk(aop, 1);
    chk(aof, 12'h101);
    chk(occ, 10);
    chk(cerr, 1);
    sel = 3'h7;
    step;
    chk(occ, 10);
  endtask : t_over
  // freeze with the enable low, then count a base unit
  task automatic t_hold;
    en = 0;
    sel = 3'h1;
    step;
    chk(xs, 12'h0E0);
    chk(occ, 10);
    en = 1;
    base = 1;
    sel = 3'h5;
    step;
    chk(occ, 12);
    chk(cerr, 1);
    base = 0;
  endtask : t_hold
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // hang guard
  initial begin
    #100000;
    err_total++;
    report_and_stop;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_b = 1;
    t_board;
    t_load;
    t_over;
    t_hold;
    report_and_stop;
  end
endmodule : testbench
